// ==== hdl/print_head_defines.svh ====
`ifndef PRINT_HEAD_DEFINES_SVH
`define PRINT_HEAD_DEFINES_SVH
// host io device and instruction codes
`define DEV_PRINT_HEAD 10'h030
`define FC_SKIP_READY 4'h0
`define FC_ENABLE_CHAN 4'h0
`define FC_CLEAR 4'h2
`define FC_STATUS 4'h9
`define INT_MASK_DEV 10'h010
`define INT_MASK_BIT 16'h2000
// block transfer pointer locations and limit
`define LOC_START 13'h0012
`define LOC_END 13'h0013
`define ADDR_LIMIT 13'h1FFF
// word formats
`define OP_FAST_END 4'hF
`define SPF_HARDCOPY 4'hD
`define SPF_TEST_CLR 4'hE
`define FAST_HI_LSB 12
`define FAST_LO_LSB 12
// status bit positions (bit 1 is msb, bit n sits at 16-n)
`define ST_NOT_READY 15
`define ST_FORM_FAIL 7
`define ST_PROC_INT 4
`define ST_CAM_INT 3
`define ST_TEST_MODE 0
// timing
`define CLK_MHZ 200
`define DELAY_MS 64
`define DELAY_CYCLES (`DELAY_MS * 1000 * `CLK_MHZ)
`define EXEC_MIN_US 2
`define EXEC_MIN_CYCLES (`EXEC_MIN_US * `CLK_MHZ)
`define PULL_PERFS 2
`define BLOCK_PERFS 242
`define PROC_INT_PERFS 4
`define PULLS_MIN 3'd2
`define PULLS_MAX 3'd6
`endif

// ==== hdl/print_head_pkg.sv ====
package print_head_pkg;
  // channel walk states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_WAIT = 3'b010,
    ST_EXEC = 3'b011,
    ST_DONE = 3'b100
  } chan_state_t;
  // command classes held while a multiword command assembles
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_PLOT = 3'b001,
    CMD_FAST = 3'b010,
    CMD_VECTOR = 3'b011,
    CMD_STROKE = 3'b100
  } cmd_kind_t;
endpackage

// ==== hdl/word_reg_file.sv ====
`timescale 1ns/1ps
// small register store holding one assembled command's words
module word_reg_file #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH]; // word store
  // write port
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  // registered read port
  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // word_reg_file

// ==== hdl/print_head_unit.sv ====
`timescale 1ns/1ps
`include "print_head_defines.svh"
// Functional notes
// RL1 - plot point: code word three, position words 1-2
// RL2 - fast plot code from nibbles, words two/three
// RL3 - code 17 in bits 1-4 ends fast
// RL4 - host gives a pair after entering fast
// RL5 - host keeps small sizes, 80 raster units
// RL6 - host supplies vector slope times 4095
// RL7 - zero length vector plots a blank
// RL8 - short settle on request for strokes
// RL9 - marked stroke word ends stroke command
// RL10 - host sets advance with void frame
// RL11 - host gives leader and delay alone
// RL12 - hardcopy expose, host follows with delay
// RL13 - special 16 with zero clears test
// RL14 - delay holds input for 64 ms
// RL15 - frame advance pulls 2 to 6
// RL16 - block mode: notch, 242 perfs, loop empty
// RL17 - fetch from loc 22 to 23, update 22
// RL18 - clear stops leader, failures, channel
// RL19 - status read loads word, clears interrupts
// RL20 - skip when ready; pulse starts channel
// RL21 - four perf processor advance sets flag
// RL22 - camera pull sets flag; mask 20000 enables
// RL23 - ready drops during command execution
module print_head_unit
  import print_head_pkg::*;
#(
  parameter int DELAY_COUNT = `DELAY_CYCLES,
  parameter int EXEC_COUNT = `EXEC_MIN_CYCLES,
  parameter int PERF_COUNT = 64
) (
  input wire logic sys_clk,
  input wire logic resetn,
  // host instruction bus
  input wire logic [9:0] io_addr,
  input wire logic skip_on_sense,
  input wire logic output_control_pulse,
  input wire logic input_to_accumulator,
  input wire logic output_from_accumulator,
  input wire logic [15:0] out_bus,
  output logic [15:0] in_bus,
  output logic in_bus_valid,
  output logic skip,
  output logic interrupt_req,
  // block transfer channel: memory reads and the start pointer write back
  output logic mem_req,
  output logic [12:0] mem_addr,
  output logic mem_we,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // print head execution side
  output logic [47:0] plot_cmd,
  output logic [2:0] plot_kind,
  output logic plot_blank,
  output logic plot_strobe,
  output logic short_settle,
  output logic hardcopy_expose,
  output logic leader_run,
  output logic block_mode,
  output logic test_mode,
  output logic [2:0] pulls_left,
  output logic proc_run,
  // machine pins, asynchronous
  input wire logic camera_pull_pin,
  input wire logic perf_pin,
  input wire logic notch_pin,
  input wire logic notcher_fitted_pin,
  input wire logic loop_empty_pin,
  input wire logic [15:0] sense_pins
);
  // pin synchronisers
  logic [5:0] pin_s1, pin_s2;
  logic [15:0] sense_s1, sense_s2;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      sense_s1 <= 16'h0000;
      sense_s2 <= 16'h0000;
    end else begin
      pin_s1 <= {camera_pull_pin, perf_pin, notch_pin, notcher_fitted_pin,
                 loop_empty_pin, 1'b0};
      pin_s2 <= pin_s1;
      sense_s1 <= sense_pins;
      sense_s2 <= sense_s1;
    end
  end
  logic cam_q, perf_q; // previous synced levels
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cam_q <= 1'b0;
      perf_q <= 1'b0;
    end else begin
      cam_q <= pin_s2[5];
      perf_q <= pin_s2[4];
    end
  end
  wire cam_edge = pin_s2[5] & ~cam_q; // one pull seen
  wire perf_edge = pin_s2[4] & ~perf_q; // one perforation seen
  // decode of host instructions
  wire sel = (io_addr == `DEV_PRINT_HEAD);
  wire ins_chan = output_control_pulse && io_addr == {`FC_ENABLE_CHAN, 6'h30};
  wire ins_clear = output_control_pulse && io_addr == {`FC_CLEAR, 6'h30};
  wire ins_status = input_to_accumulator && io_addr == {`FC_STATUS, 6'h30};
  wire ins_skip = skip_on_sense && sel;
  wire ins_mask = output_from_accumulator && io_addr == `INT_MASK_DEV;

  chan_state_t state;
  cmd_kind_t kind;
  logic chan_on; // channel flip-flop
  logic [12:0] cur_addr, end_addr;
  logic [1:0] ptr_phase; // 0 read start, 1 read end, 2 write back
  logic [1:0] word_idx;
  logic [15:0] cur_word;
  logic [31:0] busy_cnt;
  logic ready; // head can take next word
  logic int_en, proc_int, cam_int, form_fail, adv_fail;
  logic [15:0] w1; // second word of current command
  logic [15:0] rf_rdata; // first word of current command, slot zero
  logic [1:0] rf_waddr; // first word always lands in slot zero
  logic rf_we;

  word_reg_file #(.DEPTH(4), .WIDTH(16)) u_words (
    .sys_clk(sys_clk),
    .wr_en(rf_we),
    .wr_addr(rf_waddr),
    .wr_data(mem_rdata),
    .rd_addr(2'd0),
    .rd_data(rf_rdata)
  );

  // is the command in cur_word complete at word_idx
  function automatic logic cmd_complete(input cmd_kind_t k, input logic [1:0] idx,
                                        input logic [15:0] w);
    case (k)
      CMD_PLOT: cmd_complete = (idx == 2'd2);
      CMD_FAST: cmd_complete = (idx == 2'd2) || (idx == 2'd1 && w[15:12] == `OP_FAST_END);
      CMD_VECTOR: cmd_complete = (idx == 2'd3);
      CMD_STROKE: cmd_complete = w[15]; // see RL9
      default: cmd_complete = 1'b1;
    endcase
  endfunction

  // opcode class of a first word
  function automatic cmd_kind_t first_kind(input logic [15:0] w);
    case (w[15:13])
      3'b000: first_kind = CMD_PLOT;
      3'b001: first_kind = CMD_FAST;
      3'b010: first_kind = CMD_VECTOR;
      3'b011: first_kind = CMD_STROKE;
      default: first_kind = CMD_NONE;
    endcase
  endfunction

  logic fast_mode; // stays set over pairs
  assign rf_we = (state == ST_WAIT) && mem_ack && ptr_phase == 2'd3;
  // a word arriving with no command open is a first word
  assign rf_waddr = (kind == CMD_NONE && !fast_mode) ? 2'd0 : word_idx;

  // channel walk: pointer fetch, words, write back
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      chan_on <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 13'h0000;
      mem_wdata <= 16'h0000;
      cur_addr <= 13'h0000;
      end_addr <= 13'h0000;
      ptr_phase <= 2'd0;
      cur_word <= 16'h0000;
    end else if (ins_clear) begin
      state <= ST_IDLE; // see RL18
      chan_on <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: if (ins_chan) begin // see RL20
          chan_on <= 1'b1;
          ptr_phase <= 2'd0;
          mem_addr <= `LOC_START; // see RL17
          mem_req <= 1'b1;
          state <= ST_WAIT;
        end
        ST_FETCH: if (ready) begin
          mem_addr <= cur_addr;
          ptr_phase <= 2'd3;
          mem_req <= 1'b1;
          state <= ST_WAIT;
        end
        ST_WAIT: if (mem_ack) begin
          mem_req <= 1'b0;
          mem_we <= 1'b0;
          case (ptr_phase)
            2'd0: begin
              cur_addr <= mem_rdata[12:0] & `ADDR_LIMIT;
              mem_addr <= `LOC_END;
              ptr_phase <= 2'd1;
              mem_req <= 1'b1;
            end
            2'd1: begin
              end_addr <= mem_rdata[12:0] & `ADDR_LIMIT;
              state <= ST_FETCH;
            end
            2'd2: begin
              chan_on <= 1'b0;
              state <= ST_IDLE;
            end
            default: begin
              cur_word <= mem_rdata;
              state <= ST_EXEC;
            end
          endcase
        end
        ST_EXEC: begin
          if (cur_addr == end_addr) begin
            mem_addr <= `LOC_START; // see RL17
            mem_wdata <= {3'b000, cur_addr + 13'h0001};
            mem_we <= 1'b1;
            mem_req <= 1'b1;
            ptr_phase <= 2'd2;
            state <= ST_WAIT;
          end else begin
            cur_addr <= cur_addr + 13'h0001;
            state <= ST_FETCH;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // command assembly and execution start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      kind <= CMD_NONE;
      word_idx <= 2'd0;
      fast_mode <= 1'b0;
      w1 <= 16'h0000;
      plot_cmd <= 48'h0;
      plot_kind <= 3'd0;
      plot_blank <= 1'b0;
      plot_strobe <= 1'b0;
      short_settle <= 1'b0;
      hardcopy_expose <= 1'b0;
      test_mode <= 1'b0;
      busy_cnt <= 32'd0;
    end else begin
      plot_strobe <= 1'b0;
      hardcopy_expose <= 1'b0;
      if (busy_cnt != 32'd0) begin
        busy_cnt <= busy_cnt - 32'd1; // see RL23
      end
      if (ins_clear) begin
        kind <= CMD_NONE;
        word_idx <= 2'd0;
      end else if (state == ST_EXEC) begin
        busy_cnt <= 32'(EXEC_COUNT);
        if (kind == CMD_NONE && !fast_mode) begin
          kind <= first_kind(cur_word);
          word_idx <= 2'd1;
          if (first_kind(cur_word) == CMD_FAST) begin
            fast_mode <= 1'b1; // see RL4
            kind <= CMD_FAST;
          end
          if (first_kind(cur_word) == CMD_NONE) begin
            if (cur_word[15:12] == `SPF_HARDCOPY) begin
              hardcopy_expose <= 1'b1; // see RL12
            end
            if (cur_word[15:12] == `SPF_TEST_CLR && cur_word[11:8] == 4'h0) begin
              test_mode <= 1'b0; // see RL13
            end else if (cur_word[15:12] == `SPF_TEST_CLR) begin
              test_mode <= 1'b1; // nonzero field enters test mode
            end
            if (cur_word[3]) begin
              busy_cnt <= 32'(DELAY_COUNT); // see RL14
            end
          end
        end else if (fast_mode && word_idx != 2'd2 &&
                     cur_word[15:12] == `OP_FAST_END) begin
          fast_mode <= 1'b0; // see RL3
          kind <= CMD_NONE;
          word_idx <= 2'd0;
        end else if (fast_mode && word_idx != 2'd2) begin
          w1 <= cur_word;
          word_idx <= 2'd2;
        end else if (fast_mode) begin
          // code from two nibbles, position from the same words, see RL2
          plot_cmd <= {w1, cur_word, 8'h00, w1[`FAST_HI_LSB +: 4],
                       cur_word[`FAST_LO_LSB +: 4]};
          plot_kind <= CMD_FAST;
          plot_blank <= 1'b0;
          plot_strobe <= 1'b1;
          word_idx <= 2'd1;
        end else if (cmd_complete(kind, word_idx, cur_word)) begin
          plot_kind <= kind;
          plot_strobe <= 1'b1;
          plot_cmd <= {rf_rdata, w1, cur_word}; // see RL1
          // zero length vector gives a blank, see RL7
          plot_blank <= (kind == CMD_VECTOR) && (cur_word[11:0] == 12'h000);
          short_settle <= (kind == CMD_STROKE) && rf_rdata[12]; // see RL8
          kind <= CMD_NONE;
          word_idx <= 2'd0;
        end else begin
          if (word_idx == 2'd1) begin
            w1 <= cur_word;
          end
          if (kind != CMD_STROKE) begin
            word_idx <= word_idx + 2'd1;
          end
        end
      end
    end
  end

  // ready: head idle, no delay or execution pending
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ready <= 1'b0;
    end else begin
      ready <= (busy_cnt == 32'd0) && (state != ST_EXEC); // see RL23
    end
  end

  // film control: leader, block mode, camera pulls, processor
  logic [8:0] perf_cnt;
  logic [1:0] proc_perf4;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      leader_run <= 1'b0;
      block_mode <= 1'b0;
      pulls_left <= 3'd0;
      proc_run <= 1'b0;
      perf_cnt <= 9'd0;
      proc_perf4 <= 2'd0;
      adv_fail <= 1'b0;
      form_fail <= 1'b0;
    end else begin
      if (ins_clear) begin
        leader_run <= 1'b0; // see RL18
        adv_fail <= 1'b0;
        form_fail <= 1'b0;
      end else if (state == ST_EXEC && kind == CMD_NONE && !fast_mode &&
                   first_kind(cur_word) == CMD_NONE && cur_word[15:12] == 4'hC) begin
        // control word
        if (cur_word[11]) leader_run <= 1'b1;
        if (cur_word[10]) block_mode <= 1'b1;
        if (cur_word[9]) block_mode <= 1'b0;
        if (cur_word[8]) begin
          proc_run <= 1'b1;
          perf_cnt <= 9'd0;
        end
        if (cur_word[5]) begin
          // selected pulls 2..6, see RL15
          pulls_left <= (cur_word[2:0] < `PULLS_MIN) ? `PULLS_MIN :
                        (cur_word[2:0] > `PULLS_MAX) ? `PULLS_MAX : cur_word[2:0];
        end
      end
      if (cam_edge && pulls_left != 3'd0) begin
        pulls_left <= pulls_left - 3'd1;
      end
      if (cam_edge && pulls_left == 3'd0 && !leader_run) begin
        adv_fail <= 1'b1; // unexpected pull
      end
      if (proc_run && perf_edge) begin
        perf_cnt <= perf_cnt + 9'd1;
        proc_perf4 <= proc_perf4 + 2'd1;
      end
      // block mode stop: notch, or 242 perfs without notcher; loop empty always
      // with a notcher fitted the notch, not the 242 perf count, ends the run
      if (proc_run && (pin_s2[1] ||
          (block_mode && (pin_s2[2] ? pin_s2[3]
                                    : perf_cnt == 9'(`BLOCK_PERFS))))) begin
        proc_run <= 1'b0; // see RL16
      end
    end
  end
  wire proc_adv = proc_run && perf_edge && proc_perf4 == 2'd3;

  // interrupt flags; set wins over status read clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      proc_int <= 1'b0;
      cam_int <= 1'b0;
      int_en <= 1'b0;
    end else begin
      if (ins_mask) begin
        int_en <= |(out_bus & `INT_MASK_BIT); // see RL22
      end
      proc_int <= proc_adv | (proc_int & ~ins_status); // see RL21
      cam_int <= cam_edge | (cam_int & ~ins_status); // see RL22
    end
  end

  // host answers: status word, skip, interrupt
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      in_bus <= 16'h0000;
      in_bus_valid <= 1'b0;
      skip <= 1'b0;
      interrupt_req <= 1'b0;
    end else begin
      in_bus_valid <= ins_status;
      if (ins_status) begin
        // sense bits kept off the flag and unused positions
        in_bus <= sense_s2 & 16'h7E60 | // see RL19
                  16'(!ready) << `ST_NOT_READY |
                  16'(form_fail | adv_fail) << `ST_FORM_FAIL |
                  16'(proc_int) << `ST_PROC_INT |
                  16'(cam_int) << `ST_CAM_INT |
                  16'(test_mode) << `ST_TEST_MODE;
      end
      skip <= ins_skip && ready; // see RL20
      interrupt_req <= int_en & (proc_int | cam_int);
    end
  end
endmodule // print_head_unit

// ==== test/print_head_unit_props.sv ====
`timescale 1ns/1ps
// port-level checks on the print head unit
module print_head_unit_props (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [9:0] io_addr,
  input wire logic skip_on_sense,
  input wire logic input_to_accumulator,
  input wire logic skip,
  input wire logic in_bus_valid,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [12:0] mem_addr,
  input wire logic mem_we,
  input wire logic plot_strobe,
  input wire logic hardcopy_expose,
  input wire logic [2:0] pulls_left
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // a skip only ever answers a ready test
  a_skip_cause: assert property (skip |-> $past(skip_on_sense && io_addr == 10'h030))
    else $error("skip without a ready test");
  // a status read is answered on the next cycle
  a_status_answer: assert property ((input_to_accumulator && io_addr == 10'h270) |=> in_bus_valid)
    else $error("status read not answered");
  // no status answer without a status read
  a_status_cause: assert property (in_bus_valid |-> $past(input_to_accumulator && io_addr == 10'h270))
    else $error("status answer without a read");
  // an unanswered memory request holds its address
  a_req_hold: assert property ((mem_req && !mem_ack) |=> (mem_req && $stable(mem_addr)))
    else $error("memory request dropped or moved");
  // the only memory write is the start pointer update
  a_ptr_write: assert property ((mem_req && mem_we) |-> (mem_addr == 13'h0012))
    else $error("write outside the start pointer");
  // plot strobe lasts one cycle
  a_strobe_pulse: assert property (plot_strobe |=> !plot_strobe)
    else $error("plot strobe longer than one cycle");
  // hardcopy expose lasts one cycle
  a_expose_pulse: assert property (hardcopy_expose |=> !hardcopy_expose)
    else $error("expose longer than one cycle");
  // pull count never beyond six
  a_pull_range: assert property (!(pulls_left > 3'd6))
    else $error("pull count out of range");
  // main scenarios reached
  c_plot: cover property (plot_strobe);
  c_expose: cover property (hardcopy_expose);
  c_ptr: cover property (mem_req && mem_we);
endmodule // print_head_unit_props

// ==== test/host_memory_model.sv ====
`timescale 1ns/1ps
// host core memory as seen by the block transfer channel
module host_memory_model #(
  parameter int LAT = 3
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic mem_req,
  input wire logic [12:0] mem_addr,
  input wire logic mem_we,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  output logic wrote
);
  logic [15:0] mem [0:8191]; // word store, loaded by the bench
  int cnt; // wait cycles before each answer
  // answer after LAT cycles; read data is scrambled outside the answer
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      cnt <= 0;
      wrote <= 1'b0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= 0;
    end else if (mem_req && cnt == LAT) begin
      mem_ack <= 1'b1;
      if (mem_we) begin
        mem[mem_addr] <= mem_wdata;
        wrote <= 1'b1;
      end else begin
        mem_rdata <= mem[mem_addr];
      end
    end else begin
      cnt <= mem_req ? cnt + 1 : 0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // host_memory_model

// ==== test/print_head_unit_bench.sv ====
`timescale 1ns/1ps
`include "print_head_defines.svh"
module print_head_unit_bench;
  import print_head_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] io_addr = 10'h000;
  logic skip_on_sense = 1'b0;
  logic output_control_pulse = 1'b0;
  logic input_to_accumulator = 1'b0;
  logic output_from_accumulator = 1'b0;
  logic [15:0] out_bus = 16'h0000;
  logic [15:0] in_bus;
  logic in_bus_valid, skip, interrupt_req, mem_req, mem_we, mem_ack, wrote;
  logic [12:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [47:0] plot_cmd;
  logic [2:0] plot_kind, pulls_left;
  logic plot_blank, plot_strobe, short_settle, hardcopy_expose;
  logic leader_run, block_mode, test_mode, proc_run;
  logic camera_pull_pin = 1'b0;
  logic perf_pin = 1'b0;
  logic loop_empty_pin = 1'b0;
  int fails = 0;
  int n_tests = 0;
  always #2.5 sys_clk = ~sys_clk; // 200 MHz
  print_head_unit #(.DELAY_COUNT(100), .EXEC_COUNT(4)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .io_addr(io_addr),
    .skip_on_sense(skip_on_sense), .output_control_pulse(output_control_pulse),
    .input_to_accumulator(input_to_accumulator),
    .output_from_accumulator(output_from_accumulator), .out_bus(out_bus),
    .in_bus(in_bus), .in_bus_valid(in_bus_valid), .skip(skip),
    .interrupt_req(interrupt_req), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .plot_cmd(plot_cmd), .plot_kind(plot_kind), .plot_blank(plot_blank),
    .plot_strobe(plot_strobe), .short_settle(short_settle),
    .hardcopy_expose(hardcopy_expose), .leader_run(leader_run),
    .block_mode(block_mode), .test_mode(test_mode), .pulls_left(pulls_left),
    .proc_run(proc_run), .camera_pull_pin(camera_pull_pin), .perf_pin(perf_pin),
    .notch_pin(1'b0), .notcher_fitted_pin(1'b0), .loop_empty_pin(loop_empty_pin),
    .sense_pins(16'h0000));
  host_memory_model host (
    .sys_clk(sys_clk), .resetn(resetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .wrote(wrote));
  // verdict and end of run
  task summarize;
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // compare one value
  task chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // wait at falling edges for a flag, bounded, from the next falling edge on
  task automatic wait_hi(ref logic sig, input string name, input int lim);
    int i;
    @(negedge sys_clk);
    for (i = 0; i < lim && sig !== 1'b1; i++) @(negedge sys_clk);
    if (sig !== 1'b1) begin
      fails++;
      $display("Error %s expected 1 seen timeout", name);
      summarize();
    end
  endtask
  // one host instruction pulse: 0 sense, 1 control, 2 input, 3 output
  task host_op(input int kind, input logic [9:0] addr);
    @(posedge sys_clk);
    io_addr <= addr;
    skip_on_sense <= (kind == 0);
    output_control_pulse <= (kind == 1);
    input_to_accumulator <= (kind == 2);
    output_from_accumulator <= (kind == 3);
    @(posedge sys_clk);
    {skip_on_sense, output_control_pulse, input_to_accumulator} <= 3'b000;
    output_from_accumulator <= 1'b0;
    @(negedge sys_clk);
  endtask
  // block of plot, vector, fast, stroke and special words
  task scen_block;
    host.mem[18] = 16'h0100;
    host.mem[19] = 16'h0111;
    host.mem[256] = 16'h0123;
    host.mem[257] = 16'h0456;
    host.mem[258] = 16'h0041;
    host.mem[259] = 16'h4010;
    host.mem[260] = 16'h0020;
    host.mem[261] = 16'h0800;
    host.mem[262] = 16'h0000;
    host.mem[263] = 16'h2000;
    host.mem[264] = 16'h1234;
    host.mem[265] = 16'h5678;
    host.mem[266] = 16'hF000;
    host.mem[267] = 16'h7000;
    host.mem[268] = 16'h0001;
    host.mem[269] = 16'h8002;
    host.mem[270] = 16'hD000;
    host.mem[271] = 16'hC008;
    host.mem[272] = 16'hE100;
    host.mem[273] = 16'hE000;
    host_op(1, 10'h030);
    wait_hi(plot_strobe, "plot_strobe", 400);
    chk("plot_cmd", 48'h0123_0456_0041, plot_cmd);
    chk("plot_kind", {45'h0, CMD_PLOT}, {45'h0, plot_kind});
    wait_hi(plot_strobe, "vector_strobe", 400);
    chk("vector_kind", {45'h0, CMD_VECTOR}, {45'h0, plot_kind});
    chk("vector_blank", 48'h1, {47'h0, plot_blank});
    wait_hi(plot_strobe, "fast_strobe", 400);
    chk("fast_cmd", 48'h1234_5678_0015, plot_cmd);
    wait_hi(plot_strobe, "stroke_strobe", 400);
    chk("stroke_kind", {45'h0, CMD_STROKE}, {45'h0, plot_kind});
    chk("short_settle", 48'h1, {47'h0, short_settle});
    wait_hi(hardcopy_expose, "hardcopy_expose", 400);
    repeat (60) @(negedge sys_clk);
    host_op(0, 10'h030);
    chk("skip_in_delay", 48'h0, {47'h0, skip});
    chk("test_mode_held", 48'h0, {47'h0, test_mode});
    wait_hi(test_mode, "test_mode_set", 200);
    wait_hi(wrote, "pointer_write", 400);
    chk("start_pointer", 48'h0112, {32'h0, host.mem[18]});
    chk("test_mode", 48'h0, {47'h0, test_mode});
  endtask
  // ready test once the block is done
  task scen_skip;
    repeat (20) @(negedge sys_clk);
    host_op(0, 10'h030);
    chk("skip", 48'h1, {47'h0, skip});
  endtask
  // film control: pulls, processor, interrupt flags, clear
  task scen_film;
    host.mem[18] = 16'h0120;
    host.mem[19] = 16'h0122;
    host.mem[288] = 16'hC500;
    host.mem[289] = 16'hC063;
    host.mem[290] = 16'hC800;
    out_bus <= 16'h2000;
    host_op(3, 10'h010);
    host_op(1, 10'h030);
    wait_hi(leader_run, "leader_run", 400);
    chk("pulls_left", 48'h3, {45'h0, pulls_left});
    chk("block_mode", 48'h1, {47'h0, block_mode});
    chk("proc_run", 48'h1, {47'h0, proc_run});
    @(posedge sys_clk);
    camera_pull_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    camera_pull_pin <= 1'b0;
    repeat (8) begin
      repeat (4) @(posedge sys_clk);
      perf_pin <= ~perf_pin;
    end
    wait_hi(interrupt_req, "interrupt_req", 20);
    host_op(2, 10'h270);
    chk("cam_flag_set", 48'h1, {47'h0, in_bus[`ST_CAM_INT]});
    chk("proc_flag_set", 48'h1, {47'h0, in_bus[`ST_PROC_INT]});
    chk("pulls_after", 48'h2, {45'h0, pulls_left});
    host_op(2, 10'h270);
    chk("cam_flag_clear", 48'h0, {47'h0, in_bus[`ST_CAM_INT]});
    chk("proc_flag_clear", 48'h0, {47'h0, in_bus[`ST_PROC_INT]});
    chk("interrupt_clear", 48'h0, {47'h0, interrupt_req});
    @(posedge sys_clk);
    loop_empty_pin <= 1'b1;
    repeat (5) @(negedge sys_clk);
    chk("proc_stop", 48'h0, {47'h0, proc_run});
    host_op(1, 10'h0B0);
    chk("leader_clear", 48'h0, {47'h0, leader_run});
    chk("block_kept", 48'h1, {47'h0, block_mode});
  endtask
  // reset, then the scenarios
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    scen_block();
    scen_skip();
    scen_film();
    summarize();
  end
endmodule // print_head_unit_bench
bind print_head_unit print_head_unit_props u_props (
  .sys_clk(sys_clk), .resetn(resetn), .io_addr(io_addr), .skip_on_sense(skip_on_sense),
  .input_to_accumulator(input_to_accumulator), .skip(skip), .in_bus_valid(in_bus_valid),
  .mem_req(mem_req), .mem_ack(mem_ack), .mem_addr(mem_addr), .mem_we(mem_we),
  .plot_strobe(plot_strobe), .hardcopy_expose(hardcopy_expose), .pulls_left(pulls_left));
